// ### verilog/avg_fault_pkg.sv
package avg_fault_pkg;

    // command codes on the management port
    localparam logic [7:0] CMD_OUTPUT_CURRENT_STATUS = 8'h7b;
    localparam logic [7:0] CMD_AVG_OC_THRESHOLD = 8'he7;
    localparam logic [7:0] CMD_AVG_UC_THRESHOLD = 8'he8;
    localparam logic [7:0] CMD_GLOBAL_OPTIONS = 8'he9;

    // number of output pages
    localparam int PAGES = 2;

    // linear-11 field layout
    localparam int LIN_EXP_MSB = 15;
    localparam int LIN_EXP_LSB = 11;
    localparam int LIN_MAN_MSB = 10;
    localparam int LIN_MAN_LSB = 0;

    // output current status bit positions
    localparam int STATUS_OC_BIT = 7;
    localparam int STATUS_UC_BIT = 4;

    // global options word field positions
    localparam int OPT_SYNC_LSB = 1;
    localparam int OPT_SYNC_MSB = 2;
    localparam int OPT_BUS_TIMEOUT_DIS_BIT = 4;
    localparam int OPT_LINK_PUSH_PULL_BIT = 6;
    localparam int OPT_VSENSE_LSB = 8;
    localparam int OPT_VSENSE_MSB = 9;
    localparam int OPT_AUX_TEMP_BIT = 12;
    localparam logic [15:0] OPT_WRITABLE_MASK = 16'h1356;

    // sync field encodings
    localparam logic [1:0] SYNC_INTERNAL = 2'h0;
    localparam logic [1:0] SYNC_INTERNAL_DRIVE = 2'h1;
    localparam logic [1:0] SYNC_EXTERNAL = 2'h2;

    // current samples carry this many fraction bits (1/16 A)
    localparam int SAMPLE_FRAC_BITS = 4;
    localparam logic signed [15:0] CURRENT_LIMIT_POS = 16'sh0640;
    localparam logic signed [15:0] CURRENT_LIMIT_NEG = -16'sh0640;

    // blanking window at the start of each sensed interval
    localparam int BLANK_TIME_NS = 100;
    localparam int CLK_PERIOD_NS = 10;
    localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // strap settle wait after reset release
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;

    // register reset values, replaced once the strap is read
    localparam logic [15:0] RESET_AVG_OC = 16'h0000;
    localparam logic [15:0] RESET_AVG_UC = 16'h0000;
    localparam logic [15:0] RESET_OPTIONS = 16'h0000;

    // strap-selected defaults (thresholds linear-11 with exponent zero, then options words)
    localparam logic [15:0] STRAP_OC_0 = 16'h001e;
    localparam logic [15:0] STRAP_OC_1 = 16'h0028;
    localparam logic [15:0] STRAP_OC_2 = 16'h0032;
    localparam logic [15:0] STRAP_OC_3 = 16'h003c;
    localparam logic [15:0] STRAP_OPT_0 = 16'h0000;
    localparam logic [15:0] STRAP_OPT_1 = 16'h0100;
    localparam logic [15:0] STRAP_OPT_2 = 16'h1000;
    localparam logic [15:0] STRAP_OPT_3 = 16'h1100;

    typedef enum logic [1:0] {ST_SETTLE, ST_LOAD, ST_RUN} boot_state_t;

    // linear-11 to signed fixed point in sample units, clamped to the range
    function automatic logic signed [15:0] lin11_to_fixed(input logic [15:0] w);
        logic signed [4:0] expo;
        logic signed [10:0] man;
        logic signed [6:0] sh;
        logic signed [6:0] nsh;
        logic signed [31:0] v;
        begin
            expo = w[LIN_EXP_MSB:LIN_EXP_LSB];
            man = w[LIN_MAN_MSB:LIN_MAN_LSB];
            sh = 7'(expo) + 7'(SAMPLE_FRAC_BITS);
            nsh = -sh;
            v = 32'(man);
            if (sh >= 7'sh0) begin
                v = v <<< sh[4:0];
            end else begin
                v = v >>> nsh[4:0];
            end
            if (v > 32'(CURRENT_LIMIT_POS)) begin
                v = 32'(CURRENT_LIMIT_POS);
            end else if (v < 32'(CURRENT_LIMIT_NEG)) begin
                v = 32'(CURRENT_LIMIT_NEG);
            end
            lin11_to_fixed = v[15:0];
        end
    endfunction

    // negate a linear-11 word by negating its mantissa
    function automatic logic [15:0] lin11_negate(input logic [15:0] w);
        logic [10:0] man;
        begin
            man = 11'h0 - w[LIN_MAN_MSB:LIN_MAN_LSB];
            lin11_negate = {w[LIN_EXP_MSB:LIN_EXP_LSB], man};
        end
    endfunction

endpackage

// ### verilog/interval_averager.sv
`timescale 1ns/10ps
`default_nettype none

// per-cycle average comparator for one output
module interval_averager
    import avg_fault_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic sense_up,
    input wire logic pwm_on,
    input wire logic sample_valid,
    input wire logic signed [15:0] sample,
    input wire logic signed [15:0] oc_thr,
    input wire logic signed [15:0] uc_thr,
    output logic oc_event_ff,
    output logic uc_event_ff
);

    logic active_prev_ff;
    logic [7:0] blank_cnt_ff;
    logic signed [23:0] sum_ff;
    logic [7:0] count_ff;
    logic signed [24:0] oc_lim;
    logic signed [24:0] uc_lim;

    // sensed interval: on-time for up slope, off-time for down slope
    wire active = sense_up ? pwm_on : ~pwm_on;
    wire start = active & ~active_prev_ff;
    wire done = ~active & active_prev_ff;
    wire blanking = blank_cnt_ff < 8'(BLANK_CYCLES);
    wire take = active & ~start & ~blanking & sample_valid & (count_ff != 8'hff);
    wire signed [23:0] nxt_sum = start ? 24'sh0 : (take ? sum_ff + 24'(sample) : sum_ff);
    wire [7:0] nxt_count = start ? 8'h0 : (take ? count_ff + 8'h1 : count_ff);
    wire [7:0] nxt_blank = start ? 8'h1 : (blanking ? blank_cnt_ff + 8'h1 : blank_cnt_ff);

    // thresholds scaled by count so no divider is needed
    assign oc_lim = 25'(oc_thr) * $signed({1'b0, count_ff});
    assign uc_lim = 25'(uc_thr) * $signed({1'b0, count_ff});
    wire have = done & (count_ff != 8'h0);
    wire nxt_oc = have & (25'(sum_ff) > oc_lim);
    wire nxt_uc = have & (25'(sum_ff) < uc_lim);

    // interval tracking and accumulation
    always_ff @(posedge clk) begin
        if (srst) begin
            active_prev_ff <= 1'b0;
            blank_cnt_ff <= 8'h0;
            sum_ff <= 24'sh0;
            count_ff <= 8'h0;
            oc_event_ff <= 1'b0;
            uc_event_ff <= 1'b0;
        end else begin
            active_prev_ff <= active;
            blank_cnt_ff <= nxt_blank;
            sum_ff <= nxt_sum;
            count_ff <= nxt_count;
            oc_event_ff <= nxt_oc;
            uc_event_ff <= nxt_uc;
        end
    end

endmodule // interval_averager

`default_nettype wire

// ### verilog/avg_current_fault_limits.sv
`timescale 1ns/10ps
`default_nettype none

module avg_current_fault_limits
    import avg_fault_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] cfg_strap,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_cmd,
    input wire logic reg_page,
    input wire logic [15:0] reg_wdata,
    input wire logic write_protect,
    input wire logic clear_faults,
    input wire logic [1:0] sense_up,
    input wire logic [1:0] pwm_on,
    input wire logic [1:0] sample_valid,
    input wire logic signed [15:0] sample_out0,
    input wire logic signed [15:0] sample_out1,
    input wire logic [1:0] peak_oc_event,
    input wire logic [1:0] peak_uc_event,
    output logic [15:0] reg_rdata_ff,
    output logic reg_ack_ff,
    output logic reg_err_ff,
    output logic [1:0] oc_fault_ff,
    output logic [1:0] uc_fault_ff,
    output logic [7:0] status_out0_ff,
    output logic [7:0] status_out1_ff,
    output logic [1:0] vsense_sel_ff,
    output logic aux_temp_mode_ff,
    output logic bus_timeout_dis_ff,
    output logic link_push_pull_ff,
    output logic sync_use_ext_ff,
    output logic sync_drive_out_ff,
    output logic boot_done_ff
);

    // strap pin synchroniser
    logic [1:0] strap_meta_ff;
    logic [1:0] strap_sync_ff;

    // boot sequencing
    boot_state_t state_ff;
    boot_state_t nxt_state;
    logic [1:0] settle_ff;

    // register storage
    logic [15:0] oc_thr_ff [PAGES];
    logic [15:0] uc_thr_ff [PAGES];
    logic [15:0] options_ff;
    logic [PAGES-1:0] st_oc_ff;
    logic [PAGES-1:0] st_uc_ff;

    // averager results
    logic [PAGES-1:0] avg_oc;
    logic [PAGES-1:0] avg_uc;
    logic signed [15:0] sample_sel [PAGES];

    // strap-selected defaults
    function automatic logic [15:0] strap_oc(input logic [1:0] s);
        begin
            case (s)
                2'h0: strap_oc = STRAP_OC_0;
                2'h1: strap_oc = STRAP_OC_1;
                2'h2: strap_oc = STRAP_OC_2;
                default: strap_oc = STRAP_OC_3;
            endcase
        end
    endfunction

    function automatic logic [15:0] strap_opt(input logic [1:0] s);
        begin
            case (s)
                2'h0: strap_opt = STRAP_OPT_0;
                2'h1: strap_opt = STRAP_OPT_1;
                2'h2: strap_opt = STRAP_OPT_2;
                default: strap_opt = STRAP_OPT_3;
            endcase
        end
    endfunction

    // strap passes two flops before use
    always_ff @(posedge clk) begin
        if (srst) begin
            strap_meta_ff <= 2'h0;
            strap_sync_ff <= 2'h0;
        end else begin
            strap_meta_ff <= cfg_strap;
            strap_sync_ff <= strap_meta_ff;
        end
    end

    // boot: settle the synchroniser, load strap defaults, then run
    wire settle_done = settle_ff == STRAP_SETTLE_CYCLES;
    wire loading = state_ff == ST_LOAD;
    wire running = state_ff == ST_RUN;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_SETTLE: begin
                if (settle_done) begin
                    nxt_state = ST_LOAD;
                end
            end
            ST_LOAD: nxt_state = ST_RUN;
            ST_RUN: nxt_state = ST_RUN;
            default: nxt_state = ST_SETTLE;
        endcase
    end

    wire [1:0] nxt_settle = settle_done ? settle_ff : settle_ff + 2'h1;

    always_ff @(posedge clk) begin
        if (srst) begin
            state_ff <= ST_SETTLE;
            settle_ff <= 2'h0;
            boot_done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            settle_ff <= nxt_settle;
            boot_done_ff <= loading | running;
        end
    end

    // command decode
    wire hit_oc = reg_cmd == CMD_AVG_OC_THRESHOLD;
    wire hit_uc = reg_cmd == CMD_AVG_UC_THRESHOLD;
    wire hit_opt = reg_cmd == CMD_GLOBAL_OPTIONS;
    wire hit_st = reg_cmd == CMD_OUTPUT_CURRENT_STATUS;
    wire hit_rw = hit_oc | hit_uc | hit_opt;
    wire wr_ok = reg_wr & running & hit_rw & ~write_protect;
    wire wr_bad = reg_wr & ~(running & hit_rw & ~write_protect);
    wire rd_ok = reg_rd & (hit_rw | hit_st);
    wire rd_bad = reg_rd & ~(hit_rw | hit_st);
    wire [15:0] strap_oc_val = strap_oc(strap_sync_ff);
    wire [15:0] strap_opt_val = strap_opt(strap_sync_ff);

    // paged thresholds and status
    genvar p;
    generate
        for (p = 0; p < PAGES; p = p + 1) begin : g_page
            wire pg = reg_page == 1'(p);
            wire [15:0] nxt_oc_thr = loading ? strap_oc_val :
                (wr_ok & hit_oc & pg) ? reg_wdata : oc_thr_ff[p];
            wire [15:0] nxt_uc_thr = loading ? lin11_negate(strap_oc_val) :
                (wr_ok & hit_uc & pg) ? reg_wdata : uc_thr_ff[p];
            wire oc_any = avg_oc[p] | peak_oc_event[p];
            wire uc_any = avg_uc[p] | peak_uc_event[p];
            // event wins over a clear in the same cycle
            wire nxt_st_oc = oc_any | (st_oc_ff[p] & ~clear_faults);
            wire nxt_st_uc = uc_any | (st_uc_ff[p] & ~clear_faults);

            always_ff @(posedge clk) begin
                if (srst) begin
                    oc_thr_ff[p] <= RESET_AVG_OC;
                    uc_thr_ff[p] <= RESET_AVG_UC;
                    st_oc_ff[p] <= 1'b0;
                    st_uc_ff[p] <= 1'b0;
                    oc_fault_ff[p] <= 1'b0;
                    uc_fault_ff[p] <= 1'b0;
                end else begin
                    oc_thr_ff[p] <= nxt_oc_thr;
                    uc_thr_ff[p] <= nxt_uc_thr;
                    st_oc_ff[p] <= nxt_st_oc;
                    st_uc_ff[p] <= nxt_st_uc;
                    oc_fault_ff[p] <= oc_any;
                    uc_fault_ff[p] <= uc_any;
                end
            end

            // thresholds decoded to sample units, clamped to the range
            wire signed [15:0] oc_fix = lin11_to_fixed(oc_thr_ff[p]);
            wire signed [15:0] uc_fix = lin11_to_fixed(uc_thr_ff[p]);

            interval_averager u_avg (
                .clk(clk),
                .srst(srst),
                .sense_up(sense_up[p]),
                .pwm_on(pwm_on[p]),
                .sample_valid(sample_valid[p] & running),
                .sample(sample_sel[p]),
                .oc_thr(oc_fix),
                .uc_thr(uc_fix),
                .oc_event_ff(avg_oc[p]),
                .uc_event_ff(avg_uc[p])
            );
        end
    endgenerate

    // per-output sample routing
    assign sample_sel[0] = sample_out0;
    assign sample_sel[1] = sample_out1;

    // global options word, reserved bits kept at zero
    wire [15:0] nxt_options = loading ? (strap_opt_val & OPT_WRITABLE_MASK) :
        (wr_ok & hit_opt) ? (reg_wdata & OPT_WRITABLE_MASK) : options_ff;

    always_ff @(posedge clk) begin
        if (srst) begin
            options_ff <= RESET_OPTIONS;
        end else begin
            options_ff <= nxt_options;
        end
    end

    // option decode to the controlled blocks
    wire [1:0] nxt_sync = nxt_options[OPT_SYNC_MSB:OPT_SYNC_LSB];
    wire nxt_use_ext = nxt_sync == SYNC_EXTERNAL;
    wire nxt_drive_out = nxt_sync == SYNC_INTERNAL_DRIVE;
    wire [1:0] nxt_vsense = nxt_options[OPT_VSENSE_MSB:OPT_VSENSE_LSB];

    always_ff @(posedge clk) begin
        if (srst) begin
            vsense_sel_ff <= 2'h0;
            aux_temp_mode_ff <= 1'b0;
            bus_timeout_dis_ff <= 1'b0;
            link_push_pull_ff <= 1'b0;
            sync_use_ext_ff <= 1'b0;
            sync_drive_out_ff <= 1'b0;
        end else begin
            vsense_sel_ff <= nxt_vsense;
            aux_temp_mode_ff <= nxt_options[OPT_AUX_TEMP_BIT];
            bus_timeout_dis_ff <= nxt_options[OPT_BUS_TIMEOUT_DIS_BIT];
            link_push_pull_ff <= nxt_options[OPT_LINK_PUSH_PULL_BIT];
            sync_use_ext_ff <= nxt_use_ext;
            sync_drive_out_ff <= nxt_drive_out;
        end
    end

    // status bytes for each output
    wire [7:0] nxt_status0 = (8'(st_oc_ff[0]) << STATUS_OC_BIT) | (8'(st_uc_ff[0]) << STATUS_UC_BIT);
    wire [7:0] nxt_status1 = (8'(st_oc_ff[1]) << STATUS_OC_BIT) | (8'(st_uc_ff[1]) << STATUS_UC_BIT);

    always_ff @(posedge clk) begin
        if (srst) begin
            status_out0_ff <= 8'h0;
            status_out1_ff <= 8'h0;
        end else begin
            status_out0_ff <= nxt_status0;
            status_out1_ff <= nxt_status1;
        end
    end

    // read mux, selected page for paged commands
    wire [7:0] st_sel = reg_page ? nxt_status1 : nxt_status0;
    wire [15:0] rd_val = hit_oc ? oc_thr_ff[reg_page] :
        hit_uc ? uc_thr_ff[reg_page] :
        hit_opt ? options_ff :
        hit_st ? {8'h00, st_sel} : 16'h0000;
    wire [15:0] nxt_rdata = rd_ok ? rd_val : 16'h0000;
    wire nxt_ack = rd_ok | wr_ok;
    wire nxt_err = rd_bad | wr_bad;

    // one-cycle answer after each access
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata_ff <= 16'h0000;
            reg_ack_ff <= 1'b0;
            reg_err_ff <= 1'b0;
        end else begin
            reg_rdata_ff <= nxt_rdata;
            reg_ack_ff <= nxt_ack;
            reg_err_ff <= nxt_err;
        end
    end

endmodule // avg_current_fault_limits

`default_nettype wire

// ### tb/avg_fault_asserts.sv
`timescale 1ns/10ps
`default_nettype none

// port-level checks of the register port, status bits and option outputs
module avg_fault_asserts (
    input wire logic clk,
    input wire logic srst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_cmd,
    input wire logic [15:0] reg_wdata,
    input wire logic write_protect,
    input wire logic clear_faults,
    input wire logic [1:0] peak_oc_event,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic reg_ack_ff,
    input wire logic reg_err_ff,
    input wire logic [1:0] oc_fault_ff,
    input wire logic [1:0] uc_fault_ff,
    input wire logic [7:0] status_out0_ff,
    input wire logic [7:0] status_out1_ff,
    input wire logic [1:0] vsense_sel_ff,
    input wire logic aux_temp_mode_ff,
    input wire logic link_push_pull_ff,
    input wire logic sync_use_ext_ff,
    input wire logic sync_drive_out_ff
);
    import avg_fault_pkg::*;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // every access answered once, one cycle later
    property p_answer;
        (reg_rd || reg_wr) |=> (reg_ack_ff != reg_err_ff);
    endproperty
    a_answer: assert property (p_answer) else $error("access not answered once");
    property p_idle;
        !(reg_rd || reg_wr) |=> !reg_ack_ff && !reg_err_ff;
    endproperty
    a_idle: assert property (p_idle) else $error("answer without access");
    property p_protect;
        (reg_wr && write_protect) |=> reg_err_ff;
    endproperty
    a_protect: assert property (p_protect) else $error("protected write accepted");
    property p_status_ro;
        (reg_wr && reg_cmd == CMD_OUTPUT_CURRENT_STATUS) |=> reg_err_ff;
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status write accepted");
    property p_rdata_idle;
        !reg_ack_ff |-> reg_rdata_ff == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data without ack");
    // option outputs follow an accepted options write
    property p_opt_fields;
        (reg_wr && reg_cmd == CMD_GLOBAL_OPTIONS) ##1 reg_ack_ff |->
            vsense_sel_ff == $past(reg_wdata[9:8]) && aux_temp_mode_ff == $past(reg_wdata[12])
            && link_push_pull_ff == $past(reg_wdata[6]);
    endproperty
    a_opt_fields: assert property (p_opt_fields) else $error("option outputs wrong");
    property p_sync_excl;
        !(sync_use_ext_ff && sync_drive_out_ff);
    endproperty
    a_sync_excl: assert property (p_sync_excl) else $error("both sync modes active");
    // fault pulses land in the shared sticky status bits
    property p_oc_status;
        oc_fault_ff[0] |=> status_out0_ff[STATUS_OC_BIT];
    endproperty
    a_oc_status: assert property (p_oc_status) else $error("oc status bit missing");
    property p_uc_status;
        uc_fault_ff[1] |=> status_out1_ff[STATUS_UC_BIT];
    endproperty
    a_uc_status: assert property (p_uc_status) else $error("uc status bit missing");
    property p_peak;
        peak_oc_event[0] |-> ##[1:3] oc_fault_ff[0];
    endproperty
    a_peak: assert property (p_peak) else $error("peak oc not merged");
    property p_sticky;
        status_out1_ff[STATUS_OC_BIT] && !clear_faults && !$past(clear_faults)
            |=> status_out1_ff[STATUS_OC_BIT];
    endproperty
    a_sticky: assert property (p_sticky) else $error("oc status bit lost");

    c_oc: cover property (oc_fault_ff[0]);
    c_uc: cover property (uc_fault_ff[1]);
    c_protect: cover property (reg_wr && write_protect);
endmodule // avg_fault_asserts

bind avg_current_fault_limits avg_fault_asserts u_avg_fault_asserts (.clk, .srst, .reg_wr,
    .reg_rd, .reg_cmd, .reg_wdata, .write_protect, .clear_faults, .peak_oc_event,
    .reg_rdata_ff, .reg_ack_ff, .reg_err_ff, .oc_fault_ff, .uc_fault_ff, .status_out0_ff,
    .status_out1_ff, .vsense_sel_ff, .aux_temp_mode_ff, .link_push_pull_ff,
    .sync_use_ext_ff, .sync_drive_out_ff);

`default_nettype wire

// ### tb/mgmt_host.sv
`timescale 1ns/10ps
`default_nettype none

// management host: one strobed access at a time, bounded wait for the answer
module mgmt_host (
    input wire logic clk,
    input wire logic [15:0] reg_rdata_ff,
    input wire logic reg_ack_ff,
    input wire logic reg_err_ff,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_cmd,
    output logic reg_page,
    output logic [15:0] reg_wdata
);
    // idle lines at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_cmd = 8'h00;
        reg_page = 1'b0;
        reg_wdata = 16'h0000;
    end

    task automatic access(input logic wr, input logic [7:0] cmd, input logic pg,
            input logic [15:0] wd, output logic [15:0] rdata, output logic err,
            output logic lost);
        @(negedge clk);
        reg_wr = wr;
        reg_rd = !wr;
        reg_cmd = cmd;
        reg_page = pg;
        reg_wdata = wd;
        @(negedge clk);
        // released lines do not keep the last value
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_cmd = ~cmd;
        reg_page = ~pg;
        reg_wdata = ~wd;
        lost = 1'b1;
        err = 1'b0;
        rdata = 16'h0000;
        for (int n = 0; n < 4 && lost; n++) begin
            if (reg_ack_ff === 1'b1 || reg_err_ff === 1'b1) begin
                lost = 1'b0;
                err = reg_err_ff;
                rdata = reg_rdata_ff;
            end else begin
                @(negedge clk);
            end
        end
    endtask
endmodule // mgmt_host

`default_nettype wire

// ### tb/tb.sv
`timescale 1ns/10ps
`default_nettype none

module tb;
    import avg_fault_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic write_protect = 1'b0;
    logic clear_faults = 1'b0;
    logic [1:0] cfg_strap = 2'h0;
    logic [1:0] sense_up = 2'h0;
    logic [1:0] pwm_on = 2'h0;
    logic [1:0] sample_valid = 2'h0;
    logic [1:0] peak_oc_event = 2'h0;
    logic [1:0] peak_uc_event = 2'h0;
    logic signed [15:0] sample_out0 = 16'sh0;
    logic signed [15:0] sample_out1 = 16'sh0;
    wire logic reg_wr, reg_rd, reg_page, reg_ack_ff, reg_err_ff, boot_done_ff;
    wire logic [7:0] reg_cmd, status_out0_ff, status_out1_ff;
    wire logic [15:0] reg_wdata, reg_rdata_ff;
    wire logic [1:0] oc_fault_ff, uc_fault_ff, vsense_sel_ff;
    wire logic aux_temp_mode_ff, bus_timeout_dis_ff, link_push_pull_ff;
    wire logic sync_use_ext_ff, sync_drive_out_ff;
    int err_count = 0;
    int checks = 0;
    int rv;
    logic [15:0] rd, w;
    logic [15:0] thr [4];
    logic er, lost;
    localparam logic [15:0] OC_TAB [4] = '{STRAP_OC_0, STRAP_OC_1, STRAP_OC_2, STRAP_OC_3};
    localparam logic [15:0] OPT_TAB [4] = '{STRAP_OPT_0, STRAP_OPT_1, STRAP_OPT_2, STRAP_OPT_3};

    always #5 clk = ~clk;

    avg_current_fault_limits u_avg_current_fault_limits (.clk, .srst, .cfg_strap, .reg_wr,
        .reg_rd, .reg_cmd, .reg_page, .reg_wdata, .write_protect, .clear_faults, .sense_up,
        .pwm_on, .sample_valid, .sample_out0, .sample_out1, .peak_oc_event, .peak_uc_event,
        .reg_rdata_ff, .reg_ack_ff, .reg_err_ff, .oc_fault_ff, .uc_fault_ff, .status_out0_ff,
        .status_out1_ff, .vsense_sel_ff, .aux_temp_mode_ff, .bus_timeout_dis_ff,
        .link_push_pull_ff, .sync_use_ext_ff, .sync_drive_out_ff, .boot_done_ff);
    mgmt_host u_mgmt_host (.clk, .reg_rdata_ff, .reg_ack_ff, .reg_err_ff, .reg_wr, .reg_rd,
        .reg_cmd, .reg_page, .reg_wdata);

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic acc(input logic wr, input logic [7:0] cmd, input logic pg, input logic [15:0] wd);
        u_mgmt_host.access(wr, cmd, pg, wd, rd, er, lost);
        if (lost) begin
            err_count++;
            $display("ERROR answer to command %h missing", cmd);
            conclude();
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic put(input int o, input logic signed [15:0] v);
        if (o == 0) sample_out0 = v;
        else sample_out1 = v;
    endtask

    // other phase, blanked start, averaged part, then check and clear the sticky bits
    task automatic run(input int o, input logic up, input logic signed [15:0] bv, v, ov,
            input logic eo, eu);
        logic [7:0] s;
        cyc(1);
        sense_up[o] = up;
        sample_valid[o] = 1'b1;
        for (int i = 0; i < 41; i++) begin
            pwm_on[o] = (i >= 14 && i < 36) ? up : !up;
            put(o, (i < 14 || i >= 36) ? ov : (i < 24 ? bv : v));
            cyc(1);
        end
        sample_valid[o] = 1'b0;
        cyc(1);
        s = (o == 0) ? status_out0_ff : status_out1_ff;
        check("oc_status", 16'(s[STATUS_OC_BIT]), 16'(eo));
        check("uc_status", 16'(s[STATUS_UC_BIT]), 16'(eu));
        clear_faults = 1'b1;
        cyc(1);
        clear_faults = 1'b0;
        cyc(3);
        s = (o == 0) ? status_out0_ff : status_out1_ff;
        check("cleared", 16'({s[STATUS_OC_BIT], s[STATUS_UC_BIT]}), 16'h0);
    endtask

    initial begin
        void'($urandom(32'h98da));
        // strap defaults after every reset
        for (int s = 0; s < 4; s++) begin
            cfg_strap = 2'(s);
            srst = 1'b1;
            cyc(2);
            srst = 1'b0;
            cyc(10);
            check("boot", 16'(boot_done_ff), 16'h1);
            acc(0, CMD_AVG_OC_THRESHOLD, 1'b1, 16'h0);
            check("oc_default", rd, OC_TAB[s]);
            acc(0, CMD_AVG_UC_THRESHOLD, 1'b0, 16'h0);
            check("uc_default", rd, {OC_TAB[s][15:11], 11'h0 - OC_TAB[s][10:0]});
            acc(0, CMD_GLOBAL_OPTIONS, 1'b0, 16'h0);
            check("opt_default", rd, OPT_TAB[s]);
            check("vsense", 16'(vsense_sel_ff), 16'(OPT_TAB[s][9:8]));
            check("aux", 16'(aux_temp_mode_ff), 16'(OPT_TAB[s][12]));
        end
        // separate storage per page and kind
        for (int k = 0; k < 4; k++) begin
            thr[k] = 16'($urandom);
            acc(1, k[1] ? CMD_AVG_UC_THRESHOLD : CMD_AVG_OC_THRESHOLD, k[0], thr[k]);
            check("wr_ack", 16'(er), 16'h0);
        end
        for (int k = 0; k < 4; k++) begin
            acc(0, k[1] ? CMD_AVG_UC_THRESHOLD : CMD_AVG_OC_THRESHOLD, k[0], 16'h0);
            check("readback", rd, thr[k]);
        end
        write_protect = 1'b1;
        acc(1, CMD_AVG_OC_THRESHOLD, 1'b0, ~thr[0]);
        check("protect_err", 16'(er), 16'h1);
        acc(1, CMD_GLOBAL_OPTIONS, 1'b0, 16'hffff);
        check("protect_opt", 16'(er), 16'h1);
        write_protect = 1'b0;
        acc(0, CMD_AVG_OC_THRESHOLD, 1'b0, 16'h0);
        check("protect_keep", rd, thr[0]);
        acc(0, 8'h00, 1'b0, 16'h0);
        check("unmapped", {rd[14:0], er}, 16'h1);
        acc(1, CMD_OUTPUT_CURRENT_STATUS, 1'b0, 16'h0);
        check("status_ro", 16'(er), 16'h1);
        // every sync code, written on one page and read on the other
        for (int c = 0; c < 4; c++) begin
            w = (16'($urandom) & 16'hfff9) | 16'(c << 1);
            acc(1, CMD_GLOBAL_OPTIONS, c[0], w);
            acc(0, CMD_GLOBAL_OPTIONS, !c[0], 16'h0);
            check("options", rd, w & 16'h1356);
            check("sync", 16'({sync_use_ext_ff, sync_drive_out_ff}), 16'({c == 2, c == 1}));
            check("link", 16'(link_push_pull_ff), 16'(w[6]));
            check("timeout", 16'(bus_timeout_dis_ff), 16'(w[4]));
        end
        // 30 A limits, page one with other exponents
        acc(1, CMD_AVG_OC_THRESHOLD, 1'b0, 16'h001e);
        acc(1, CMD_AVG_UC_THRESHOLD, 1'b0, 16'h07e2);
        acc(1, CMD_AVG_OC_THRESHOLD, 1'b1, 16'hf83c);
        acc(1, CMD_AVG_UC_THRESHOLD, 1'b1, 16'h0ff1);
        run(0, 1'b0, 16'sh0000, 16'sh0200, -16'sh0640, 1'b1, 1'b0);
        run(0, 1'b0, 16'sh0500, 16'sh0000, 16'sh0500, 1'b0, 1'b0);
        run(1, 1'b1, -16'sh0500, -16'sh0200, 16'sh0500, 1'b0, 1'b1);
        run(1, 1'b1, 16'sh0000, 16'sh01e0, 16'sh0000, 1'b0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rv = int'($urandom_range(3200)) - 1600;
            run(i % 2, i[1], 16'(rv), 16'(rv), 16'(-rv), rv > 480, rv < -480);
        end
        // peak events share the same status bits
        peak_oc_event = 2'h3;
        peak_uc_event[0] = 1'b1;
        cyc(1);
        peak_oc_event = 2'h0;
        peak_uc_event = 2'h0;
        cyc(4);
        check("peak_oc", 16'(status_out1_ff[STATUS_OC_BIT]), 16'h1);
        check("peak_uc", 16'(status_out0_ff[STATUS_UC_BIT]), 16'h1);
        acc(0, CMD_OUTPUT_CURRENT_STATUS, 1'b1, 16'h0);
        check("status_read", 16'(rd[STATUS_OC_BIT]), 16'h1);
        conclude();
    end
endmodule // tb

`default_nettype wire
